// File: inc/uac_defs.vh
/*
  Shared constants for the asynchronous serial unit: field positions,
  reset values, parity codes and buffer sizing.
  Assumes it is included by bare name from the core file in logic/.
*/
`ifndef UAC_DEFS_VH
`define UAC_DEFS_VH

// data and buffer sizing
`define UAC_DATA_W        8
`define UAC_FIFO_DEPTH    8
`define UAC_FIFO_AW       3

// reset values of the two data registers
`define UAC_RXBUF_RESET   8'hff
`define UAC_TXSH_RESET    8'hff

// parity select codes {parity_sel_hi, parity_sel_lo}
`define UAC_PAR_NONE      2'h0
`define UAC_PAR_ZERO      2'h1
`define UAC_PAR_ODD       2'h2
`define UAC_PAR_EVEN      2'h3

// baud_gen_control field positions
`define UAC_BGC_W         7
`define UAC_BGC_SRC_HI    6
`define UAC_BGC_SRC_LO    5
`define UAC_BGC_DIV_HI    4
`define UAC_BGC_DIV_LO    0

// base clock source codes: system clock divided by 1, 2, 4, 8
`define UAC_SRC_DIV1      2'h0
`define UAC_SRC_DIV2      2'h1
`define UAC_SRC_DIV4      2'h2
`define UAC_SRC_DIV8      2'h3

// divider value used when the divisor field is zero
`define UAC_DIV_ZERO_K    6'h20
`define UAC_CNT_W         6

// prescaler and bit counter widths
`define UAC_PRE_W         3
`define UAC_BIT_W         3

`endif

// File: logic/uac_fifo.v
/*
  Parameterised synchronous FIFO with valid/ready on both sides.
  Assumes one clock, a synchronous active-low reset, a clock-run enable
  that freezes all state, and a synchronous clear from the owner.
*/
`timescale 1ns/10ps
`default_nettype none
module uac_fifo #(
  parameter W  = 8,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire          clk,       // system clock
  input  wire          rstn,      // synchronous reset, active low
  input  wire          run,       // clock supply present
  input  wire          clr,       // synchronous flush
  input  wire          in_valid,  // write request
  output wire          in_ready,  // space available
  input  wire [W-1:0]  in_data,   // write data
  output wire          out_valid, // data available
  input  wire          out_ready, // consumer takes the head
  output wire [W-1:0]  out_data   // head word
);
  reg  [W-1:0] mem [0:D-1];
  reg  [AW-1:0] wr_ptr;
  reg  [AW-1:0] rd_ptr;
  reg  [AW:0]   count;
  wire          push;
  wire          pop;

  assign in_ready  = (count != D[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (run && push && !clr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else if (run) begin
      if (clr) begin
        wr_ptr <= {AW{1'b0}};
        rd_ptr <= {AW{1'b0}};
        count  <= {(AW+1){1'b0}};
      end else begin
        if (push) begin
          wr_ptr <= wr_ptr + 1'b1;
        end
        if (pop) begin
          rd_ptr <= rd_ptr + 1'b1;
        end
        if (push && !pop) begin
          count <= count + 1'b1;
        end else if (pop && !push) begin
          count <= count - 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: logic/uac_core.v
/*
  Asynchronous serial unit: baud base clock selection and divider,
  enable synchronisers, transmitter with a write FIFO ahead of the
  transmit shifter, receiver with receive shifter, receive buffer and
  error flags.
  Assumes the CPU side runs on SYS_CLK, SERIAL_IN_PIN is asynchronous,
  and UNIT_CLK_ON low models a stopped clock supply.
*/
`timescale 1ns/10ps
`default_nettype none
`include "uac_defs.vh"

// Summary of operation
// - stop mode or asynchronous serial mode only
// - power enable low idles unit, saves power
// - seven or eight data bits, both directions
// - five-bit divider sets the bit period
// - transmit and receive enabled independently
// - base clock chosen from four sources
// - data shifted least significant bit first
// - stopped clock freezes registers and output
// - enables synced to base clock, two-cycle gap
// - receive shifter hidden from software
// - completed character moves into receive buffer
// - seven-bit character zeroes buffer top bit
// - overrun discards new character, buffer kept
// - receive buffer read only
// - receive buffer all ones on reset/power off
// - transmit write queued in FIFO, frame starts when shifter idle
// - transmit shifter cannot be read back
// - transmit shifter ones on reset/power/disable
// - parity none, zero, odd or even
// - one or two stop bits; receiver checks one
// - power off resets unit, holds input high
module uac_core (
  input  wire                  SYS_CLK,           // system clock, 50 MHz
  input  wire                  RSTN,              // synchronous reset, active low
  input  wire                  UNIT_CLK_ON,       // clock supply to the unit present
  input  wire                  UNIT_POWER_ENABLE, // unit power/clock enable
  input  wire                  TRANSMIT_ENABLE,   // transmit path enable
  input  wire                  RECEIVE_ENABLE,    // receive path enable
  input  wire                  PARITY_SEL_HI,     // parity select, upper bit
  input  wire                  PARITY_SEL_LO,     // parity select, lower bit
  input  wire                  CHAR_LEN_8,        // 1: eight data bits, 0: seven
  input  wire                  STOP_LENGTH_SEL,   // 1: two stop bits on transmit
  input  wire [`UAC_BGC_W-1:0] BAUD_GEN_CONTROL,  // clock source and divisor
  input  wire                  TX_WRITE,          // write strobe to transmit write FIFO
  input  wire [`UAC_DATA_W-1:0] TX_DATA,          // character to send
  output wire                  TX_READY,          // write accepted this cycle
  output wire                  TX_BUSY,           // frame in progress
  output reg                   TX_DONE_IRQ,       // transmission complete pulse
  input  wire                  RX_READ,           // receive buffer read strobe
  output wire [`UAC_DATA_W-1:0] RECEIVE_BUFFER,   // received character
  output reg                   RX_FULL,           // buffer holds an unread character
  input  wire                  ERR_READ,          // error status read strobe
  output reg                   OVERRUN_FLAG,      // overrun error
  output reg                   PARITY_FLAG,       // parity error
  output reg                   FRAMING_FLAG,      // framing error
  input  wire                  SERIAL_IN_PIN,     // serial receive input
  output reg                   SERIAL_OUT_PIN     // serial transmit output
);
  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_START = 5'h02;
  localparam [4:0] ST_DATA  = 5'h04;
  localparam [4:0] ST_PAR   = 5'h08;
  localparam [4:0] ST_STOP  = 5'h10;

  wire                      run;
  wire                      pwr;
  wire [1:0]                par_mode;
  wire                      par_on;
  wire [`UAC_BIT_W-1:0]     last_bit;
  wire [1:0]                src_sel;
  wire [`UAC_CNT_W-1:0]     bit_k;
  wire [`UAC_CNT_W-1:0]     half_k;
  reg  [`UAC_PRE_W-1:0]     pre_cnt;
  reg                       base_tick;
  reg                       tx_en_s1;
  reg                       tx_en_s2;
  reg                       rx_en_s1;
  reg                       rx_en_s2;
  wire                      tx_on;
  wire                      rx_on;
  reg                       pin_s1;
  reg                       pin_s2;
  reg                       pin_s3;
  reg                       pin_filt;
  wire                      rx_pin;
  wire                      fifo_valid;
  wire [`UAC_DATA_W-1:0]    fifo_data;
  wire                      fifo_pop;
  wire                      fifo_clr;
  wire                      fifo_in_ready;
  reg  [4:0]                tx_state;
  reg  [`UAC_DATA_W-1:0]    tx_shift;  // write only, no read path
  reg  [`UAC_CNT_W-1:0]     tx_cnt;
  reg  [`UAC_BIT_W-1:0]     tx_bits;
  reg                       tx_par;
  reg                       tx_stop2;
  wire                      tx_edge;
  reg  [4:0]                rx_state;
  reg  [`UAC_DATA_W-1:0]    rx_shift;
  reg  [`UAC_DATA_W-1:0]    rx_buf;
  reg  [`UAC_CNT_W-1:0]     rx_cnt;
  reg  [`UAC_BIT_W-1:0]     rx_bits;
  reg                       rx_par;
  wire [`UAC_CNT_W-1:0]     rx_lim;
  wire                      rx_edge;

  // no update at all while the clock supply is stopped
  assign run      = UNIT_CLK_ON;
  // power enable low is the stop mode
  assign pwr      = UNIT_POWER_ENABLE;
  assign par_mode = {PARITY_SEL_HI, PARITY_SEL_LO};
  assign par_on   = (par_mode != `UAC_PAR_NONE);
  assign last_bit = CHAR_LEN_8 ? 3'h7 : 3'h6;

  // base clock selection and bit divider
  assign src_sel = BAUD_GEN_CONTROL[`UAC_BGC_SRC_HI:`UAC_BGC_SRC_LO];
  assign bit_k   = (BAUD_GEN_CONTROL[`UAC_BGC_DIV_HI:`UAC_BGC_DIV_LO] == 5'h00) ?
                   `UAC_DIV_ZERO_K :
                   {1'b0, BAUD_GEN_CONTROL[`UAC_BGC_DIV_HI:`UAC_BGC_DIV_LO]};
  assign half_k  = (bit_k[`UAC_CNT_W-1:1] == 5'h00) ? 6'h01 : {1'b0, bit_k[`UAC_CNT_W-1:1]};

  always @* begin
    case (src_sel)
      `UAC_SRC_DIV1: base_tick = 1'b1;
      `UAC_SRC_DIV2: base_tick = pre_cnt[0];
      `UAC_SRC_DIV4: base_tick = &pre_cnt[1:0];
      `UAC_SRC_DIV8: base_tick = &pre_cnt;
      default:       base_tick = 1'b1;
    endcase
  end

  always @(posedge SYS_CLK) begin
    if (!RSTN) begin
      pre_cnt <= {`UAC_PRE_W{1'b0}};
    end else if (run) begin
      if (!pwr) begin
        pre_cnt <= {`UAC_PRE_W{1'b0}};
      end else begin
        pre_cnt <= pre_cnt + 1'b1;
      end
    end
  end

  // path enables pass two base clock stages before taking effect
  always @(posedge SYS_CLK) begin
    if (!RSTN) begin
      tx_en_s1 <= 1'b0;
      tx_en_s2 <= 1'b0;
      rx_en_s1 <= 1'b0;
      rx_en_s2 <= 1'b0;
    end else if (run) begin
      if (!pwr) begin
        tx_en_s1 <= 1'b0;
        tx_en_s2 <= 1'b0;
        rx_en_s1 <= 1'b0;
        rx_en_s2 <= 1'b0;
      end else if (base_tick) begin
        tx_en_s1 <= TRANSMIT_ENABLE;
        tx_en_s2 <= tx_en_s1;
        rx_en_s1 <= RECEIVE_ENABLE;
        rx_en_s2 <= rx_en_s1;
      end
    end
  end

  assign tx_on = pwr & tx_en_s2;
  assign rx_on = pwr & rx_en_s2;

  // serial input synchroniser and agreement filter
  always @(posedge SYS_CLK) begin
    if (!RSTN) begin
      pin_s1   <= 1'b1;
      pin_s2   <= 1'b1;
      pin_s3   <= 1'b1;
      pin_filt <= 1'b1;
    end else if (run) begin
      pin_s1 <= SERIAL_IN_PIN;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_filt <= pin_s3;
      end
    end
  end

  assign rx_pin = pwr ? pin_filt : 1'b1;

  // transmit write buffer ahead of the transmit shifter
  assign fifo_clr = ~tx_on;
  assign fifo_pop = (tx_state == ST_IDLE) & tx_on & fifo_valid;

  uac_fifo #(
    .W  (`UAC_DATA_W),
    .D  (`UAC_FIFO_DEPTH),
    .AW (`UAC_FIFO_AW)
  ) i_uac_fifo (
    .clk       (SYS_CLK),
    .rstn      (RSTN),
    .run       (run),
    .clr       (fifo_clr),
    .in_valid  (TX_WRITE),
    .in_ready  (fifo_in_ready),
    .in_data   (TX_DATA),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // writes are refused while the path is off, so ready must not show
  assign TX_READY = fifo_in_ready & tx_on;
  assign TX_BUSY = (tx_state != ST_IDLE) | fifo_valid;
  assign tx_edge = base_tick & (tx_cnt == bit_k - 6'h01);

  // transmitter: start, data lsb first, optional parity, stop bits
  always @(posedge SYS_CLK) begin
    if (!RSTN) begin
      tx_state       <= ST_IDLE;
      tx_shift       <= `UAC_TXSH_RESET;
      tx_cnt         <= {`UAC_CNT_W{1'b0}};
      tx_bits        <= {`UAC_BIT_W{1'b0}};
      tx_par         <= 1'b0;
      tx_stop2       <= 1'b0;
      SERIAL_OUT_PIN <= 1'b1;
      TX_DONE_IRQ    <= 1'b0;
    end else if (run) begin
      TX_DONE_IRQ <= 1'b0;
      if (!tx_on) begin
        tx_state       <= ST_IDLE;
        tx_shift       <= `UAC_TXSH_RESET;
        tx_cnt         <= {`UAC_CNT_W{1'b0}};
        tx_bits        <= {`UAC_BIT_W{1'b0}};
        tx_par         <= 1'b0;
        tx_stop2       <= 1'b0;
        SERIAL_OUT_PIN <= 1'b1;
      end else begin
        if (tx_state != ST_IDLE && base_tick) begin
          tx_cnt <= tx_edge ? {`UAC_CNT_W{1'b0}} : tx_cnt + 6'h01;
        end
        case (tx_state)
          ST_IDLE: begin
            if (fifo_valid) begin
              tx_shift       <= fifo_data;
              tx_cnt         <= {`UAC_CNT_W{1'b0}};
              tx_par         <= 1'b0;
              SERIAL_OUT_PIN <= 1'b0;
              tx_state       <= ST_START;
            end
          end
          ST_START: begin
            if (tx_edge) begin
              SERIAL_OUT_PIN <= tx_shift[0];
              tx_par         <= tx_shift[0];
              tx_shift       <= {1'b1, tx_shift[`UAC_DATA_W-1:1]};
              tx_bits        <= {`UAC_BIT_W{1'b0}};
              tx_state       <= ST_DATA;
            end
          end
          ST_DATA: begin
            if (tx_edge) begin
              if (tx_bits == last_bit) begin
                tx_stop2 <= 1'b0;
                if (par_on) begin
                  case (par_mode)
                    `UAC_PAR_ODD:  SERIAL_OUT_PIN <= ~tx_par;
                    `UAC_PAR_EVEN: SERIAL_OUT_PIN <= tx_par;
                    default:       SERIAL_OUT_PIN <= 1'b0;
                  endcase
                  tx_state <= ST_PAR;
                end else begin
                  SERIAL_OUT_PIN <= 1'b1;
                  tx_state       <= ST_STOP;
                end
              end else begin
                SERIAL_OUT_PIN <= tx_shift[0];
                tx_par         <= tx_par ^ tx_shift[0];
                tx_shift       <= {1'b1, tx_shift[`UAC_DATA_W-1:1]};
                tx_bits        <= tx_bits + 3'h1;
              end
            end
          end
          ST_PAR: begin
            if (tx_edge) begin
              SERIAL_OUT_PIN <= 1'b1;
              tx_state       <= ST_STOP;
            end
          end
          ST_STOP: begin
            if (tx_edge) begin
              if (STOP_LENGTH_SEL && !tx_stop2) begin
                tx_stop2 <= 1'b1;
              end else begin
                tx_shift    <= `UAC_TXSH_RESET;
                TX_DONE_IRQ <= 1'b1;
                tx_state    <= ST_IDLE;
              end
            end
          end
          default: begin
            tx_state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign rx_lim  = (rx_state == ST_START) ? half_k : bit_k;
  assign rx_edge = base_tick & (rx_cnt == rx_lim - 6'h01);

  // receive shifter is internal only; the buffer is the read view
  assign RECEIVE_BUFFER = rx_buf;

  // receiver: samples at mid-bit, single stop bit checked
  always @(posedge SYS_CLK) begin
    if (!RSTN) begin
      rx_state     <= ST_IDLE;
      rx_shift     <= `UAC_RXBUF_RESET;
      rx_buf       <= `UAC_RXBUF_RESET;
      rx_cnt       <= {`UAC_CNT_W{1'b0}};
      rx_bits      <= {`UAC_BIT_W{1'b0}};
      rx_par       <= 1'b0;
      RX_FULL      <= 1'b0;
      OVERRUN_FLAG <= 1'b0;
      PARITY_FLAG  <= 1'b0;
      FRAMING_FLAG <= 1'b0;
    end else if (run) begin
      // clears first so a same-cycle set below wins
      if (ERR_READ) begin
        OVERRUN_FLAG <= 1'b0;
        PARITY_FLAG  <= 1'b0;
        FRAMING_FLAG <= 1'b0;
      end
      if (RX_READ) begin
        RX_FULL <= 1'b0;
      end
      if (!pwr) begin
        rx_state     <= ST_IDLE;
        rx_shift     <= `UAC_RXBUF_RESET;
        rx_buf       <= `UAC_RXBUF_RESET;
        rx_cnt       <= {`UAC_CNT_W{1'b0}};
        RX_FULL      <= 1'b0;
        OVERRUN_FLAG <= 1'b0;
        PARITY_FLAG  <= 1'b0;
        FRAMING_FLAG <= 1'b0;
      end else if (!rx_on) begin
        rx_state     <= ST_IDLE;
        rx_cnt       <= {`UAC_CNT_W{1'b0}};
        OVERRUN_FLAG <= 1'b0;
        PARITY_FLAG  <= 1'b0;
        FRAMING_FLAG <= 1'b0;
      end else begin
        if (rx_state != ST_IDLE && base_tick) begin
          rx_cnt <= rx_edge ? {`UAC_CNT_W{1'b0}} : rx_cnt + 6'h01;
        end
        case (rx_state)
          ST_IDLE: begin
            if (!rx_pin) begin
              rx_cnt   <= {`UAC_CNT_W{1'b0}};
              rx_par   <= 1'b0;
              rx_state <= ST_START;
            end
          end
          ST_START: begin
            if (rx_edge) begin
              rx_bits  <= {`UAC_BIT_W{1'b0}};
              rx_state <= rx_pin ? ST_IDLE : ST_DATA;
            end
          end
          ST_DATA: begin
            if (rx_edge) begin
              rx_shift <= {rx_pin, rx_shift[`UAC_DATA_W-1:1]};
              rx_par   <= rx_par ^ rx_pin;
              rx_bits  <= rx_bits + 3'h1;
              if (rx_bits == last_bit) begin
                rx_state <= par_on ? ST_PAR : ST_STOP;
              end
            end
          end
          ST_PAR: begin
            if (rx_edge) begin
              // zero parity is taken but never judged
              if ((par_mode == `UAC_PAR_ODD && !(rx_par ^ rx_pin)) ||
                  (par_mode == `UAC_PAR_EVEN && (rx_par ^ rx_pin))) begin
                PARITY_FLAG <= 1'b1;
              end
              rx_state <= ST_STOP;
            end
          end
          ST_STOP: begin
            if (rx_edge) begin
              if (!rx_pin) begin
                FRAMING_FLAG <= 1'b1;
              end
              if (RX_FULL && !RX_READ) begin
                OVERRUN_FLAG <= 1'b1;
              end else begin
                rx_buf  <= CHAR_LEN_8 ? rx_shift :
                           {1'b0, rx_shift[`UAC_DATA_W-1:1]};
                RX_FULL <= 1'b1;
              end
              rx_state <= ST_IDLE;
            end
          end
          default: begin
            rx_state <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/uac_core_chk.sv
/* Port checker for uac_core.
   Assumes a bind to uac_core and the single SYS_CLK domain. */
`timescale 1ns/10ps
`default_nettype none
module uac_core_chk (
  input wire logic       SYS_CLK,           // clock
  input wire logic       RSTN,              // reset
  input wire logic       UNIT_CLK_ON,       // supply on
  input wire logic       UNIT_POWER_ENABLE, // power
  input wire logic       PARITY_SEL_HI,     // parity hi
  input wire logic       PARITY_SEL_LO,     // parity lo
  input wire logic       CHAR_LEN_8,        // length
  input wire logic       TX_WRITE,          // write
  input wire logic       TX_READY,          // ready
  input wire logic       TX_BUSY,           // busy
  input wire logic       TX_DONE_IRQ,       // done
  input wire logic [7:0] RECEIVE_BUFFER,    // buffer
  input wire logic       RX_FULL,           // unread
  input wire logic       OVERRUN_FLAG,      // overrun
  input wire logic       PARITY_FLAG,       // parity error
  input wire logic       SERIAL_OUT_PIN     // line out
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  sequence wr_idle;
    TX_WRITE && TX_READY && !TX_BUSY && UNIT_CLK_ON;
  endsequence
  sequence wr_run;
    wr_idle ##1 UNIT_CLK_ON;
  endsequence
  start_low_a: assert property (wr_run |=> !SERIAL_OUT_PIN)
    else $error("start bit not on time");
  busy_set_a: assert property (TX_WRITE && TX_READY && UNIT_CLK_ON |=> TX_BUSY)
    else $error("accepted write left no busy");
  done_stop_a: assert property (
    TX_DONE_IRQ |-> SERIAL_OUT_PIN && !$past(TX_DONE_IRQ)) else $error("bad done pulse");
  stop_buf_a: assert property (
    !UNIT_POWER_ENABLE && UNIT_CLK_ON |=> RECEIVE_BUFFER == 8'hff && !RX_FULL)
    else $error("buffer not all ones in stop mode");
  stop_tx_a: assert property (
    !UNIT_POWER_ENABLE && UNIT_CLK_ON |=> SERIAL_OUT_PIN && !TX_BUSY && !OVERRUN_FLAG)
    else $error("transmitter not reset in stop mode");
  freeze_hold_a: assert property (
    !UNIT_CLK_ON |=> $stable(SERIAL_OUT_PIN) && $stable(RECEIVE_BUFFER) && $stable(RX_FULL))
    else $error("state moved without clock supply");
  msb_zero_a: assert property (!CHAR_LEN_8 && $rose(RX_FULL) |-> !RECEIVE_BUFFER[7])
    else $error("seven-bit character with top bit set");
  ovr_keep_a: assert property ($rose(OVERRUN_FLAG) |-> $stable(RECEIVE_BUFFER) && RX_FULL)
    else $error("overrun replaced buffer");
  zero_par_a: assert property (
    !PARITY_SEL_HI && PARITY_SEL_LO && !$past(PARITY_FLAG) |-> !PARITY_FLAG)
    else $error("zero parity was checked");
  buf_new_a: assert property (
    $changed(RECEIVE_BUFFER) && UNIT_POWER_ENABLE |-> RX_FULL) else $error("stray buffer change");
endmodule
bind uac_core uac_core_chk i_uac_core_chk (
  .SYS_CLK(SYS_CLK), .RSTN(RSTN), .UNIT_CLK_ON(UNIT_CLK_ON),
  .UNIT_POWER_ENABLE(UNIT_POWER_ENABLE), .PARITY_SEL_HI(PARITY_SEL_HI),
  .PARITY_SEL_LO(PARITY_SEL_LO), .CHAR_LEN_8(CHAR_LEN_8), .TX_WRITE(TX_WRITE),
  .TX_READY(TX_READY), .TX_BUSY(TX_BUSY), .TX_DONE_IRQ(TX_DONE_IRQ),
  .RECEIVE_BUFFER(RECEIVE_BUFFER), .RX_FULL(RX_FULL), .OVERRUN_FLAG(OVERRUN_FLAG),
  .PARITY_FLAG(PARITY_FLAG), .SERIAL_OUT_PIN(SERIAL_OUT_PIN));
`default_nettype wire

// File: verif/uac_peer.sv
/* Remote serial device: sends frames on request, captures frames.
   Assumes the bench sets the bit period and the frame length. */
`timescale 1ns/10ps
`default_nettype none
module uac_peer (
  input  wire logic       clk,     // system clock
  input  wire logic [7:0] bitp,    // clocks per bit
  input  wire logic [3:0] nb,      // data and parity bits
  input  wire logic       line_in, // device output
  output var  logic       line_out // device input
);
  logic [9:0] q[$];
  logic [9:0] w;
  initial line_out = 1'b1; // idle high
  // capture at bit centres, stop bit lands at index nb
  always begin
    @(negedge line_in); // start bit
    w = '0;
    repeat (bitp / 2) @(posedge clk);
    for (int i = 0; i <= nb; i++) begin
      repeat (bitp) @(posedge clk);
      w[i] = line_in;
    end
    q.push_back(w);
  end
  task automatic send(input logic [9:0] v);
    @(posedge clk);
    line_out <= 1'b0;
    for (int i = 0; i <= nb; i++) begin
      repeat (bitp) @(posedge clk);
      line_out <= v[i];
    end
    repeat (bitp) @(posedge clk);
    line_out <= 1'b1; // back to idle even after a broken stop bit
    repeat (bitp) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: verif/uac_core_tb_top.sv
/* Bench for uac_core: transmit, receive, errors, freeze, stop mode, FIFO.
   Assumes the peer model on the serial pins and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module uac_core_tb_top;
  logic       clk = 1'b0, rstn = 1'b0, con = 1'b1, pwr = 1'b0, te = 1'b0, re = 1'b0;
  logic       ph = 1'b0, pl = 1'b0, l8 = 1'b1, s2 = 1'b0, wr = 1'b0, rrd = 1'b0, erd = 1'b0;
  logic [6:0] bgc = 7'h04;
  logic [7:0] wd = 8'h00, rbuf, bitp = 8'h04;
  logic [3:0] nb = 4'h8;
  logic       rdy, busy, done, full, ovr, perr, ferr, sin, sout;
  int         failures = 0, n_compared = 0;
  uac_core i_uac_core (.SYS_CLK(clk), .RSTN(rstn), .UNIT_CLK_ON(con), .UNIT_POWER_ENABLE(pwr),
    .TRANSMIT_ENABLE(te), .RECEIVE_ENABLE(re), .PARITY_SEL_HI(ph), .PARITY_SEL_LO(pl),
    .CHAR_LEN_8(l8), .STOP_LENGTH_SEL(s2), .BAUD_GEN_CONTROL(bgc), .TX_WRITE(wr),
    .TX_DATA(wd), .TX_READY(rdy), .TX_BUSY(busy), .TX_DONE_IRQ(done), .RX_READ(rrd),
    .RECEIVE_BUFFER(rbuf), .RX_FULL(full), .ERR_READ(erd), .OVERRUN_FLAG(ovr),
    .PARITY_FLAG(perr), .FRAMING_FLAG(ferr), .SERIAL_IN_PIN(sin), .SERIAL_OUT_PIN(sout));
  uac_peer i_uac_peer (.clk(clk), .bitp(bitp), .nb(nb), .line_in(sout), .line_out(sin));
  always #10 clk = ~clk;
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // frame bits after start: data lsb first, parity, stop
  function automatic logic [9:0] fr(input logic [7:0] d, input logic f8, input logic [1:0] p);
    logic [9:0] v;
    int         nd;
    nd = f8 ? 8 : 7;
    v = {2'b00, f8 ? d : {1'b0, d[6:0]}};
    if (p != 2'h0) v[nd] = (p == 2'h1) ? 1'b0 : (p == 2'h2) ? ~^v : ^v;
    v[nd + (p != 2'h0)] = 1'b1;
    return v;
  endfunction
  task automatic cfg(input logic [1:0] src, input logic [1:0] p, input logic f8, input logic t2);
    @(posedge clk);
    te <= 1'b0;
    re <= 1'b0;
    repeat (20) @(posedge clk); // two base ticks even at the slowest source
    {ph, pl} <= p;
    l8 <= f8;
    s2 <= t2;
    bgc <= {src, 5'h04};
    bitp <= 8'h04 << src;
    nb <= (f8 ? 4'h8 : 4'h7) + (p != 2'h0);
    @(posedge clk);
    te <= 1'b1;
    re <= 1'b1;
    repeat (20) @(posedge clk);
  endtask
  task automatic put(input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wr <= 1'b1;
    wd <= d;
    do @(negedge clk); while (rdy !== 1'b1 && ++n < 2000);
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic take(input logic [9:0] exp);
    for (int n = 0; n < 5000 && i_uac_peer.q.size() == 0; n++) @(posedge clk);
    chk(i_uac_peer.q.size() ? i_uac_peer.q.pop_front() : ~exp, exp);
  endtask
  task automatic rd();
    @(posedge clk);
    rrd <= 1'b1;
    erd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    erd <= 1'b0;
    @(negedge clk);
  endtask
  task automatic t_reset();
    @(negedge clk);
    chk({rbuf, sout, rdy}, {8'hff, 2'b10});
    @(posedge clk);
    pwr <= 1'b1;
    $display("t_reset done");
  endtask
  task automatic t_tx();
    for (int s = 0; s < 4; s++) begin
      cfg(s[1:0], s[1:0], s[0], s[1]);
      put(8'hc3 ^ s[7:0]);
      take(fr(8'hc3 ^ s[7:0], s[0], s[1:0]));
      for (int n = 0; n < 1000 && done !== 1'b1; n++) @(posedge clk);
      chk(done, 1'b1);
    end
    $display("t_tx done");
  endtask
  task automatic t_rx();
    cfg(2'h0, 2'h0, 1'b1, 1'b0);
    i_uac_peer.send(fr(8'h3c, 1'b1, 2'h0));
    @(negedge clk);
    chk({rbuf, full}, {8'h3c, 1'b1});
    rd();
    cfg(2'h0, 2'h2, 1'b0, 1'b0);
    i_uac_peer.send(fr(8'hd5, 1'b0, 2'h2));
    i_uac_peer.send(fr(8'h2a, 1'b0, 2'h2));
    @(negedge clk);
    chk({rbuf, ovr, perr}, {8'h55, 2'b10});
    @(posedge clk);
    con <= 1'b0;
    rrd <= 1'b1;
    repeat (4) @(posedge clk);
    con <= 1'b1;
    rrd <= 1'b0;
    @(negedge clk);
    chk({rbuf, full, sout}, {8'h55, 2'b11});
    rd();
    i_uac_peer.send(fr(8'h11, 1'b0, 2'h2) ^ 10'h080);
    @(negedge clk);
    chk({rbuf, perr, ovr}, {8'h11, 2'b10});
    rd();
    cfg(2'h0, 2'h1, 1'b1, 1'b0);
    i_uac_peer.send(fr(8'h11, 1'b1, 2'h1) ^ 10'h100);
    @(negedge clk);
    chk({rbuf, perr, full}, {8'h11, 2'b01});
    rd();
    i_uac_peer.send(fr(8'h5a, 1'b1, 2'h1) ^ 10'h200);
    @(negedge clk);
    chk({rbuf, ferr, full}, {8'h5a, 2'b11});
    $display("t_rx done");
  endtask
  task automatic t_stop();
    @(posedge clk);
    te <= 1'b0;
    re <= 1'b0;
    repeat (20) @(posedge clk);
    pwr <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({rbuf, full, sout}, {8'hff, 2'b01});
    @(posedge clk);
    pwr <= 1'b1;
    $display("t_stop done");
  endtask
  task automatic t_fifo();
    cfg(2'h0, 2'h0, 1'b1, 1'b0);
    for (int i = 0; i < 9; i++) put(8'h30 + i[7:0]);
    @(negedge clk);
    chk(rdy, 1'b0);
    for (int i = 0; i < 9; i++) take(fr(8'h30 + i[7:0], 1'b1, 2'h0));
    $display("t_fifo done");
  endtask
  task automatic results();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #1_500_000;
    failures++;
    results();
  end
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_stop();
    t_fifo();
    results();
  end
endmodule
`default_nettype wire
